// file: verilog/lpmc_regs.svh
// Constants of the low-power mode controller
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH
`define LPMC_CLK_HZ          50000000
`define LPMC_WAKE_STBY_US    10
`define LPMC_WAKE_DEEP_US    350
`define LPMC_WAKE_STBY_CYC   ((`LPMC_CLK_HZ / 1000000) * `LPMC_WAKE_STBY_US)
`define LPMC_WAKE_DEEP_CYC   ((`LPMC_CLK_HZ / 1000000) * `LPMC_WAKE_DEEP_US)
`define LPMC_CEIL_RUN_KHZ    16'h3E80
`define LPMC_CEIL_LOW_KHZ    16'h0028
`define LPMC_CEIL_OFF_KHZ    16'h0000
`define LPMC_SVS_RST         1'b1
`endif

// file: verilog/lpmc_pkg.sv
// Types of the low-power mode controller
package lpmc_pkg;
  typedef enum logic [2:0] {
    LPMC_RUN,
    LPMC_HALT,
    LPMC_STBY,
    LPMC_DEEP,
    LPMC_TIMER,
    LPMC_SHUT
  } lpmc_mode_t;

  typedef enum logic [1:0] {
    LPMC_ACTIVE,
    LPMC_LOW,
    LPMC_WAKING,
    LPMC_ISR
  } lpmc_phase_t;

  typedef struct packed {
    logic main_clk;
    logic sub_clk;
    logic freq_lock_loop;
    logic tunable_oscillator;
    logic mod_clk;
    logic ref_osc;
    logic aux_clk;
    logic xtal_clk;
    logic vlo_clk;
  } lpmc_clk_en_t;

  typedef struct packed {
    logic core_supply;
    logic supervisor;
    logic brownout;
  } lpmc_pwr_t;

  typedef struct packed {
    logic [3:0] src;
    logic       sync1;
    logic       sync2;
  } lpmc_wake_sync_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
  } lpmc_timer_state_t;

  typedef struct packed {
    lpmc_phase_t  phase;
    lpmc_mode_t   mode;
    lpmc_mode_t   saved;
    lpmc_clk_en_t clk;
    lpmc_pwr_t    pwr;
    logic [15:0]  ceil_khz;
  } lpmc_state_t;
endpackage

// file: verilog/lpmc_wake_sync.sv
// Two-flop synchroniser for the asynchronous wake-up pins
`timescale 1ns/1ps
module lpmc_wake_sync
  import lpmc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // Asynchronous pins and synchronised copy
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_sync_out
);
  logic [3:0] stage1_reg;
  logic [3:0] stage2_reg;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_bit
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
        end else begin
          stage1_reg[i] <= pin_in[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign pin_sync_out = stage2_reg;
endmodule

// file: verilog/lpmc_wake_timer.sv
// Down-counter that times the wake-up latency
`timescale 1ns/1ps
module lpmc_wake_timer
  import lpmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Start with a load value, done pulses once at expiry
  input  wire logic        start_in,
  input  wire logic [15:0] load_in,
  output logic             done_out
);
  lpmc_timer_state_t st_reg;
  lpmc_timer_state_t st_next;
  logic              done_next;
  logic              done_reg;

  always_comb begin
    st_next   = st_reg;
    done_next = 1'b0;
    if (start_in) begin
      st_next.cnt  = load_in;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt <= 16'h0001) begin
        st_next.busy = 1'b0;
        st_next.cnt  = 16'h0000;
        done_next    = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg   <= '0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      done_reg <= done_next;
    end
  end

  assign done_out = done_reg;
endmodule

// file: verilog/lpmc_ctrl.sv
// Low-power mode controller: mode register, clock gating, supply and wake-up
//
// Behaviour
// - One run state, five software-selected low-power states
// - Pending interrupt wakes halt and standby states
// - Interrupt return re-enters previous low-power state
// - Timer-only and shutdown states cut core supply
// - Clock ceiling 16 MHz, 40 kHz or zero
// - Fast clocks allowed only in run or halt
// - Reference and aux clocks off from deep-off down
// - Crystal and VLO clocks off in shutdown, and in deep-off unless requested
// - Wake latency: instant, 10 us, 350 us
// - Wake sources restricted per low-power state
// - Supervisor forced on in run and halt
// - Brown-out detection on in every state
// - Deep-off keeps low clocks when peripherals request
`timescale 1ns/1ps
`include "lpmc_regs.svh"
module lpmc_ctrl
  import lpmc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rstn_in,
  // Processor core requests
  input  wire logic         enter_req_in,
  input  wire lpmc_mode_t   enter_mode_in,
  input  wire logic         isr_return_in,
  // Software enables for optional clocks and supervisor
  input  wire lpmc_clk_en_t clk_opt_in,
  input  wire logic         svs_opt_in,
  // Wake sources: internal interrupt, calendar counter, pins
  input  wire logic         irq_pending_in,
  input  wire logic         rtc_event_in,
  input  wire logic [3:0]   wake_pin_in,
  // Low-frequency peripheral requests for slow clocks
  input  wire logic         lf_periph_req_in,
  // Mode and phase status
  output lpmc_mode_t        mode_out,
  output lpmc_phase_t       phase_out,
  output logic              cpu_run_out,
  output logic              wake_done_out,
  // Clock and supply enables
  output lpmc_clk_en_t      clk_en_out,
  output lpmc_pwr_t         pwr_out,
  output logic [15:0]       clk_ceiling_khz_out
);
  localparam logic [15:0] WAKE_STBY = 16'(`LPMC_WAKE_STBY_CYC);
  localparam logic [15:0] WAKE_DEEP = 16'(`LPMC_WAKE_DEEP_CYC);

  lpmc_state_t st_reg;
  lpmc_state_t st_next;
  logic [3:0]  pin_sync;
  logic        timer_start;
  logic [15:0] timer_load;
  logic        timer_done;
  logic        wake_ok;
  logic        pin_evt;

  lpmc_wake_sync u_sync (
    .clk_sys_in   (clk_sys_in),
    .rstn_in      (rstn_in),
    .pin_in       (wake_pin_in),
    .pin_sync_out (pin_sync)
  );

  lpmc_wake_timer u_timer (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .start_in   (timer_start),
    .load_in    (timer_load),
    .done_out   (timer_done)
  );

  assign pin_evt = |pin_sync;

  // Which events may end each low-power state
  always_comb begin
    wake_ok = 1'b0;
    unique case (st_reg.mode)
      LPMC_RUN:   wake_ok = 1'b0;
      LPMC_HALT:  wake_ok = irq_pending_in | rtc_event_in | pin_evt;
      LPMC_STBY:  wake_ok = irq_pending_in | rtc_event_in | pin_evt;
      LPMC_DEEP:  wake_ok = pin_evt;
      LPMC_TIMER: wake_ok = rtc_event_in | pin_evt;
      LPMC_SHUT:  wake_ok = pin_evt;
    endcase
  end

  // Wake-up latency per state
  always_comb begin
    timer_load = 16'h0000;
    unique case (st_reg.mode)
      LPMC_RUN, LPMC_HALT:  timer_load = 16'h0000;
      LPMC_STBY, LPMC_DEEP: timer_load = WAKE_STBY;
      LPMC_TIMER, LPMC_SHUT: timer_load = WAKE_DEEP;
    endcase
  end

  assign timer_start = (st_reg.phase == LPMC_LOW) && wake_ok
                       && (st_reg.mode != LPMC_HALT);

  // Enable tables derived from a mode
  function automatic lpmc_clk_en_t clk_for(input lpmc_mode_t m, input lpmc_clk_en_t opt,
                                           input logic lf_req);
    lpmc_clk_en_t c;
    c = '0;
    c.main_clk = (m == LPMC_RUN);
    if (m == LPMC_RUN || m == LPMC_HALT) begin
      c.sub_clk = opt.sub_clk;
      c.freq_lock_loop     = opt.freq_lock_loop;
      c.tunable_oscillator     = opt.tunable_oscillator;
      c.mod_clk = opt.mod_clk;
    end
    if (m == LPMC_RUN || m == LPMC_HALT || m == LPMC_STBY) begin
      c.ref_osc = opt.ref_osc;
      c.aux_clk = opt.aux_clk;
    end
    if (m == LPMC_RUN || m == LPMC_HALT || m == LPMC_STBY || m == LPMC_TIMER) begin
      c.xtal_clk = opt.xtal_clk;
      c.vlo_clk  = opt.vlo_clk;
    end else if (m == LPMC_DEEP) begin
      c.xtal_clk = opt.xtal_clk & lf_req;
      c.vlo_clk  = opt.vlo_clk & lf_req;
    end
    return c;
  endfunction

  function automatic lpmc_pwr_t pwr_for(input lpmc_mode_t m, input logic svs_opt);
    lpmc_pwr_t p;
    p.core_supply = !(m == LPMC_TIMER || m == LPMC_SHUT);
    p.supervisor  = (m == LPMC_RUN || m == LPMC_HALT) ? 1'b1 : svs_opt;
    p.brownout    = 1'b1;
    return p;
  endfunction

  function automatic logic [15:0] ceil_for(input lpmc_mode_t m);
    logic [15:0] v;
    v = `LPMC_CEIL_OFF_KHZ;
    unique case (m)
      LPMC_RUN, LPMC_HALT:   v = `LPMC_CEIL_RUN_KHZ;
      LPMC_STBY, LPMC_TIMER: v = `LPMC_CEIL_LOW_KHZ;
      LPMC_DEEP, LPMC_SHUT:  v = `LPMC_CEIL_OFF_KHZ;
    endcase
    return v;
  endfunction

  // Mode sequencer
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.phase)
      LPMC_ACTIVE: begin
        if (enter_req_in && enter_mode_in != LPMC_RUN) begin
          st_next.mode  = enter_mode_in;
          st_next.saved = enter_mode_in;
          st_next.phase = LPMC_LOW;
        end else if (isr_return_in && st_reg.saved != LPMC_RUN) begin
          st_next.mode  = st_reg.saved;
          st_next.phase = LPMC_LOW;
        end
      end
      LPMC_LOW: begin
        if (wake_ok) begin
          if (st_reg.mode == LPMC_HALT) begin
            st_next.mode  = LPMC_RUN;
            st_next.phase = LPMC_ISR;
          end else begin
            st_next.phase = LPMC_WAKING;
          end
        end
      end
      LPMC_WAKING: begin
        if (timer_done) begin
          st_next.mode = LPMC_RUN;
          // Cut-supply states restart; others service and return
          if (st_reg.mode == LPMC_TIMER || st_reg.mode == LPMC_SHUT) begin
            st_next.saved = LPMC_RUN;
            st_next.phase = LPMC_ACTIVE;
          end else begin
            st_next.phase = LPMC_ISR;
          end
        end
      end
      LPMC_ISR: begin
        if (isr_return_in) begin
          st_next.mode  = st_reg.saved;
          st_next.phase = LPMC_LOW;
        end else if (enter_req_in && enter_mode_in == LPMC_RUN) begin
          st_next.saved = LPMC_RUN;
          st_next.phase = LPMC_ACTIVE;
        end
      end
    endcase
    st_next.clk      = clk_for(st_next.mode, clk_opt_in, lf_periph_req_in);
    st_next.pwr      = pwr_for(st_next.mode, svs_opt_in);
    st_next.ceil_khz = ceil_for(st_next.mode);
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg.phase          <= LPMC_ACTIVE;
      st_reg.mode           <= LPMC_RUN;
      st_reg.saved          <= LPMC_RUN;
      st_reg.clk            <= '0;
      st_reg.clk.main_clk   <= 1'b1;
      st_reg.pwr.core_supply <= 1'b1;
      st_reg.pwr.supervisor <= `LPMC_SVS_RST;
      st_reg.pwr.brownout   <= 1'b1;
      st_reg.ceil_khz       <= `LPMC_CEIL_RUN_KHZ;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mode_out            = st_reg.mode;
  assign phase_out           = st_reg.phase;
  assign cpu_run_out         = (st_reg.mode == LPMC_RUN);
  assign wake_done_out       = timer_done;
  assign clk_en_out          = st_reg.clk;
  assign pwr_out             = st_reg.pwr;
  assign clk_ceiling_khz_out = st_reg.ceil_khz;
endmodule

// file: test/lpmc_core_model.sv
// Processor core model: raises interrupts and returns from its routine
`timescale 1ns/1ps
module lpmc_core_model
  import lpmc_pkg::*;
(
  // Clock and controller phase
  input  wire logic        clk_in,
  input  wire lpmc_phase_t phase_in,
  // Test commands
  input  wire logic        irq_cmd_in,
  input  wire logic [7:0]  ret_dly_in,
  // Interrupt pending and routine return
  output logic             irq_out,
  output logic             ret_out
);
  logic [7:0] wait_reg = 8'h00;
  initial ret_out = 1'b0;
  // Pending until the routine is entered
  assign irq_out = irq_cmd_in && phase_in != LPMC_ISR;
  // Routine lasts ret_dly_in + 1 cycles, then returns once
  always @(negedge clk_in) begin
    wait_reg <= (phase_in == LPMC_ISR) ? wait_reg + 8'h01 : 8'h00;
    ret_out  <= phase_in == LPMC_ISR && wait_reg == ret_dly_in;
  end
endmodule

// file: test/lpmc_ctrl_monitor.sv
// Port checker of the low-power mode controller
`timescale 1ns/1ps
module lpmc_ctrl_monitor
  import lpmc_pkg::*;
(
  // Clock, reset and requests
  input wire logic         clk_sys_in,
  input wire logic         rstn_in,
  input wire logic         enter_req_in,
  input wire lpmc_mode_t   enter_mode_in,
  input wire logic         isr_return_in,
  input wire logic         irq_pending_in,
  // Outputs watched
  input wire lpmc_mode_t   mode_out,
  input wire lpmc_phase_t  phase_out,
  input wire logic         wake_done_out,
  input wire lpmc_clk_en_t clk_en_out,
  input wire lpmc_pwr_t    pwr_out,
  input wire logic [15:0]  clk_ceiling_khz_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_main_run: assert property (clk_en_out.main_clk == (mode_out == LPMC_RUN))
    else $error("main clock enable wrong");
  a_fast_off: assert property (mode_out > LPMC_HALT |-> clk_en_out[7:4] == 4'h0)
    else $error("fast clock on in low state");
  a_core_cut: assert property (pwr_out.core_supply == (mode_out < LPMC_TIMER))
    else $error("core supply wrong");
  a_svs_forced: assert property (mode_out < LPMC_STBY |-> pwr_out.supervisor)
    else $error("supervisor off in run or halt");
  a_brownout_on: assert property (pwr_out.brownout)
    else $error("brownout off");
  a_ceiling_value: assert property (clk_ceiling_khz_out ==
    (mode_out < LPMC_STBY ? 16'h3E80 :
     mode_out inside {LPMC_STBY, LPMC_TIMER} ? 16'h0028 : 16'h0000))
    else $error("clock ceiling wrong");
  a_halt_wake: assert property (mode_out == LPMC_HALT && phase_out == LPMC_LOW &&
    irq_pending_in |=> mode_out == LPMC_RUN && phase_out == LPMC_ISR)
    else $error("halt not woken");
  a_enter_take: assert property (phase_out == LPMC_ACTIVE && enter_req_in &&
    enter_mode_in != LPMC_RUN && !isr_return_in
    |=> mode_out == $past(enter_mode_in) && phase_out == LPMC_LOW)
    else $error("request not taken");
  a_done_run: assert property (wake_done_out |-> ##[0:1] mode_out == LPMC_RUN)
    else $error("no run after wake");
endmodule
bind lpmc_ctrl lpmc_ctrl_monitor mon (.clk_sys_in, .rstn_in, .enter_req_in, .enter_mode_in,
  .isr_return_in, .irq_pending_in, .mode_out, .phase_out, .wake_done_out, .clk_en_out,
  .pwr_out, .clk_ceiling_khz_out);

// file: test/testbench.sv
// Self-checking testbench of the low-power mode controller
`timescale 1ns/1ps
module testbench;
  import lpmc_pkg::*;
  logic         clk_sys_in       = 1'b0;
  logic         rstn_in          = 1'b0;
  logic         enter_req_in     = 1'b0;
  logic         rtc_event_in     = 1'b0;
  logic         lf_periph_req_in = 1'b0;
  logic         svs_opt_in       = 1'b0;
  logic         irq_cmd          = 1'b0;
  logic [3:0]   wake_pin_in      = 4'h0;
  logic [7:0]   ret_dly          = 8'h00;
  lpmc_mode_t   enter_mode_in    = LPMC_RUN;
  lpmc_clk_en_t clk_opt_in       = 9'h1FF;
  logic         isr_return_in;
  logic         irq_pending_in;
  logic         cpu_run_out;
  logic         wake_done_out;
  lpmc_mode_t   mode_out;
  lpmc_phase_t  phase_out;
  lpmc_clk_en_t clk_en_out;
  lpmc_pwr_t    pwr_out;
  logic [15:0]  clk_ceiling_khz_out;
  logic [8:0]   exp_clk [6]  = '{9'h1FF, 9'h0FF, 9'h00F, 9'h000, 9'h003, 9'h000};
  logic [15:0]  exp_ceil [6] = '{16'h3E80, 16'h3E80, 16'h0028, 16'h0000, 16'h0028, 16'h0000};
  int           miscompares  = 0;
  int           checks       = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  lpmc_ctrl dut (.clk_sys_in, .rstn_in, .enter_req_in, .enter_mode_in, .isr_return_in,
    .clk_opt_in, .svs_opt_in, .irq_pending_in, .rtc_event_in, .wake_pin_in, .lf_periph_req_in,
    .mode_out, .phase_out, .cpu_run_out, .wake_done_out, .clk_en_out, .pwr_out,
    .clk_ceiling_khz_out);
  lpmc_core_model core (.clk_in(clk_sys_in), .phase_in(phase_out), .irq_cmd_in(irq_cmd),
    .ret_dly_in(ret_dly), .irq_out(irq_pending_in), .ret_out(isr_return_in));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic do_reset();
    rstn_in = 1'b0;
    step(8);
    chk("reset clocks", 16'h0100, 16'(clk_en_out));
    chk("reset power", 16'h0007, 16'(pwr_out));
    rstn_in = 1'b1;
    step(1);
  endtask
  task automatic drive(int s, logic v);
    case (s)
      0: irq_cmd = v;
      1: rtc_event_in = v;
      default: wake_pin_in[s-2] = v;
    endcase
  endtask
  task automatic enter(lpmc_mode_t m);
    logic [8:0] c;
    logic [2:0] p;
    // Optional clocks follow the software enables; the main clock ignores them
    c = (exp_clk[m] | ((m == LPMC_DEEP && lf_periph_req_in) ? 9'h003 : 9'h000))
        & (clk_opt_in | 9'h100);
    p = {m < LPMC_TIMER, m < LPMC_STBY || svs_opt_in, 1'b1};
    enter_req_in = 1'b1;
    enter_mode_in = m;
    step(1);
    enter_req_in = 1'b0;
    step(1);
    chk("mode", 16'(m), 16'(mode_out));
    chk("clocks", 16'(c), 16'(clk_en_out));
    chk("pwr", 16'(p), 16'(pwr_out));
    chk("ceiling", exp_ceil[m], clk_ceiling_khz_out);
  endtask
  task automatic refuse(int s);
    drive(s, 1'b1);
    step(8);
    chk("refused wake", 16'(LPMC_LOW), 16'(phase_out));
    drive(s, 1'b0);
    step(4);
  endtask
  task automatic wake(int s, lpmc_mode_t m, int lat, logic back);
    int n;
    drive(s, 1'b1);
    for (n = 0; n < 20000 && phase_out inside {LPMC_LOW, LPMC_WAKING}; n++) step(1);
    drive(s, 1'b0);
    chk("wake cycles", 16'(lat), 16'(n >= lat && n <= lat + 8 ? lat : n));
    if (n == 20000) results();
    chk("woken mode", 16'(LPMC_RUN), 16'(mode_out));
    chk("core run", 16'h0001, 16'(cpu_run_out));
    if (back) begin
      for (n = 0; n < 100 && phase_out != LPMC_LOW; n++) step(1);
      chk("restored phase", 16'(LPMC_LOW), 16'(phase_out));
      if (n == 100) results();
      chk("restored mode", 16'(m), 16'(mode_out));
    end else
      chk("restart phase", 16'(LPMC_ACTIVE), 16'(phase_out));
  endtask
  task automatic t_halt();
    do_reset();
    ret_dly = 8'h05;
    clk_opt_in = 9'h0A5;
    enter(LPMC_HALT);
    wake(0, LPMC_HALT, 0, 1'b1);
    clk_opt_in = 9'h1FF;
  endtask
  task automatic t_stby();
    do_reset();
    ret_dly = 8'h00;
    enter(LPMC_STBY);
    wake(1, LPMC_STBY, 500, 1'b1);
    wake(2, LPMC_STBY, 500, 1'b1);
  endtask
  task automatic t_deep();
    do_reset();
    enter(LPMC_DEEP);
    refuse(0);
    refuse(1);
    wake(3, LPMC_DEEP, 500, 1'b1);
    do_reset();
    lf_periph_req_in = 1'b1;
    enter(LPMC_DEEP);
    lf_periph_req_in = 1'b0;
    step(2);
    chk("lf released", 16'h0000, 16'(clk_en_out));
  endtask
  task automatic t_timer();
    do_reset();
    svs_opt_in = 1'b1;
    enter(LPMC_TIMER);
    refuse(0);
    wake(1, LPMC_TIMER, 17500, 1'b0);
    svs_opt_in = 1'b0;
  endtask
  task automatic t_shut();
    do_reset();
    enter(LPMC_SHUT);
    refuse(1);
    wake(5, LPMC_SHUT, 17500, 1'b0);
  endtask
  initial begin
    t_halt();
    t_stby();
    t_deep();
    t_timer();
    t_shut();
    results();
  end
endmodule
